/* core/lpi_init_seq.sv */
// memory-side power-up, auto-initialisation and calibration sequencer
//
// Added by the designer: register access over APB and the register addresses.
`timescale 1ns/1ns
//Function
// - outputs high impedance while CKE low
// - auto-init finishes within 10 us
// - idle, banks precharged after auto-init
// - ZQ command ignored when unsupported
// - calibration result reported in info register
// - auto-init loads default register values
// - reset outside power-up restarts sequence
// - info bit 0 is busy flag
module lpi_init_seq #(
	parameter int AUTO_CYC = lpi_pkg::AUTOINIT_CYC,
	parameter int ZQ_CYC = lpi_pkg::ZQINIT_CYC
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic memClk,
	input wire logic cke,
	input wire logic csN,
	input wire logic [2:0] cmdCode,
	input wire logic [7:0] cmdAddr,
	input wire logic [7:0] cmdData,
	output logic [7:0] rdData,
	output logic rdValid,
	output logic dqOeN,
	output logic memIdle,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	import lpi_pkg::*;

	localparam logic [7:0] AUTO_LAST = 8'(AUTO_CYC - 1);
	localparam logic [7:0] ZQ_LAST = 8'(ZQ_CYC - 1);

	lpi_regs_t r;
	lpi_regs_t next_r;
	logic [21:0] pinSync;
	logic sClk;
	logic sCke;
	logic sCsN;
	logic [2:0] sCmd;
	logic [7:0] sAddr;
	logic [7:0] sData;
	logic clkRise;
	logic cmdValid;
	logic isMrw;
	logic isMrr;

	// ---------------------------------------------------------------
	// pin synchronisation
	// ---------------------------------------------------------------
	lpi_sync #(
		.WIDTH(22)
	) u_sync (
		.ref_clk(ref_clk),
		.rstn(rstn),
		.async({memClk, cke, csN, cmdCode, cmdAddr, cmdData}),
		.synced(pinSync)
	);

	assign {sClk, sCke, sCsN, sCmd, sAddr, sData} = pinSync;
	// commands are taken on the rising link clock edge with CKE high
	assign clkRise = sClk && !r.clkPrev;
	assign cmdValid = clkRise && sCke && !sCsN;
	assign isMrw = cmdValid && (sCmd == CMD_MRW);
	assign isMrr = cmdValid && (sCmd == CMD_MRR);

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.clkPrev = sClk;
		next_r.rdValid = 1'b0;
		next_r.dqOeN = 1'b1;
		next_r.pready = 1'b0;
		next_r.pslverr = 1'b0;

		// sequencer
		unique case (r.state)
			S_POWER: begin
				if (sCke) begin
					next_r.state = S_NOPWAIT;
				end
			end
			S_NOPWAIT: begin
			end
			S_AUTOINIT: begin
				if (r.cnt == AUTO_LAST) begin
					next_r.busy = 1'b0;
					next_r.state = S_IDLE;
				end else begin
					next_r.cnt = r.cnt + 8'h01;
				end
			end
			S_IDLE: begin
				if (isMrw && sAddr == MA_ZQCAL && r.zqSupport) begin
					next_r.state = S_ZQCAL;
					next_r.cnt = 8'h00;
				end
			end
			S_ZQCAL: begin
				if (r.cnt == ZQ_LAST) begin
					next_r.rzq = r.zqResult;
					next_r.state = S_IDLE;
				end else begin
					next_r.cnt = r.cnt + 8'h01;
				end
			end
			default: begin
				next_r.state = S_POWER;
			end
		endcase

		// mode register writes
		if (isMrw && r.state != S_POWER) begin
			if (sAddr == MA_RESET) begin
				// reset restarts auto-init from any state except S_POWER
				next_r.state = S_AUTOINIT;
				next_r.cnt = 8'h00;
				next_r.busy = 1'b1;
				next_r.rzq = RZQ_RESET;
				next_r.feat1 = FEAT1_DEFAULT;
				next_r.feat2 = FEAT2_DEFAULT;
				next_r.iocfg = IOCFG_DEFAULT;
				next_r.resets = r.resets + 8'h01;
			end else if (r.state == S_IDLE) begin
				if (sAddr == MA_FEAT1) begin
					next_r.feat1 = sData;
				end else if (sAddr == MA_FEAT2) begin
					next_r.feat2 = sData;
				end else if (sAddr == MA_IOCFG) begin
					next_r.iocfg = sData;
				end
			end
		end

		// mode register reads
		if (isMrr) begin
			next_r.rdValid = 1'b1;
			next_r.dqOeN = 1'b0;
			if (sAddr == MA_INFO) begin
				next_r.rdData = 8'h00;
				next_r.rdData[INFO_BUSY_BIT] = r.busy;
				next_r.rdData[INFO_RZQ_LSB +: 2] = r.rzq;
			end else begin
				next_r.rdData = 8'h00;
			end
		end
		if (!sCke) begin
			next_r.dqOeN = 1'b1;
		end

		// apb slave, answer ready in the access cycle
		if (psel && !penable) begin
			next_r.pready = 1'b1;
			next_r.prdata = 32'h0000_0000;
			unique case (paddr)
				REG_CTRL: next_r.prdata = {29'h0, r.zqResult, r.zqSupport};
				REG_STATUS: next_r.prdata = {24'h0, r.rzq, r.busy, sCke, 1'b0, r.state};
				REG_FEAT1: next_r.prdata = {24'h0, r.feat1};
				REG_FEAT2: next_r.prdata = {24'h0, r.feat2};
				REG_IOCFG: next_r.prdata = {24'h0, r.iocfg};
				REG_RESETS: next_r.prdata = {24'h0, r.resets};
				default: next_r.pslverr = 1'b1;
			endcase
		end
		if (psel && penable && r.pready && pwrite && paddr == REG_CTRL) begin
			next_r.zqSupport = pwdata[0];
			next_r.zqResult = pwdata[2:1];
		end
		if (psel && penable && r.pready) begin
			next_r.pslverr = 1'b0;
		end
		if (psel && penable && r.pready && !r.pslverr) begin
			next_r.prdata = r.prdata;
		end

		// idle flag registered from the next state
		next_r.idle = (next_r.state == S_IDLE);
	end

	// ---------------------------------------------------------------
	// state register
	// ---------------------------------------------------------------
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			r.state <= S_POWER;
			r.idle <= 1'b0;
			r.cnt <= 8'h00;
			r.clkPrev <= 1'b0;
			r.busy <= 1'b1;
			r.rzq <= RZQ_RESET;
			r.feat1 <= FEAT1_DEFAULT;
			r.feat2 <= FEAT2_DEFAULT;
			r.iocfg <= IOCFG_DEFAULT;
			r.zqSupport <= CTRL_RESET[0];
			r.zqResult <= CTRL_RESET[2:1];
			r.resets <= 8'h00;
			r.rdData <= 8'h00;
			r.rdValid <= 1'b0;
			r.dqOeN <= 1'b1;
			r.prdata <= 32'h0000_0000;
			r.pready <= 1'b0;
			r.pslverr <= 1'b0;
		end else begin
			r <= next_r;
		end
	end

	assign rdData = r.rdData;
	assign rdValid = r.rdValid;
	assign dqOeN = r.dqOeN;
	// idle means every bank precharged
	assign memIdle = r.idle;
	assign prdata = r.prdata;
	assign pready = r.pready;
	assign pslverr = r.pslverr;
endmodule

/* core/lpi_pkg.sv */
// constants and types for the power-up and reset sequencing logic
package lpi_pkg;

	// ---------------------------------------------------------------
	// clock and timing
	// ---------------------------------------------------------------
	localparam int REF_PERIOD_NS = 100;
	localparam int T_INIT5_NS = 10000;
	localparam int T_ZQINIT_NS = 1000;
	// longest time rounds down
	localparam int AUTOINIT_CYC = T_INIT5_NS / REF_PERIOD_NS;
	// least time rounds up
	localparam int ZQINIT_CYC = (T_ZQINIT_NS + REF_PERIOD_NS - 1) / REF_PERIOD_NS;

	// ---------------------------------------------------------------
	// link command encoding
	// ---------------------------------------------------------------
	localparam logic [2:0] CMD_NOP = 3'h0;
	localparam logic [2:0] CMD_MRW = 3'h1;
	localparam logic [2:0] CMD_MRR = 3'h2;
	localparam logic [2:0] CMD_PREA = 3'h3;
	localparam logic [2:0] CMD_PDE = 3'h4;

	// ---------------------------------------------------------------
	// mode register addresses and layout
	// ---------------------------------------------------------------
	localparam logic [7:0] MA_INFO = 8'h00;
	localparam logic [7:0] MA_FEAT1 = 8'h01;
	localparam logic [7:0] MA_FEAT2 = 8'h02;
	localparam logic [7:0] MA_IOCFG = 8'h03;
	localparam logic [7:0] MA_ZQCAL = 8'h0A;
	localparam logic [7:0] MA_RESET = 8'h3F;
	localparam int INFO_BUSY_BIT = 0;
	localparam int INFO_RZQ_LSB = 3;
	localparam logic [7:0] FEAT1_DEFAULT = 8'h00;
	localparam logic [7:0] FEAT2_DEFAULT = 8'h00;
	localparam logic [7:0] IOCFG_DEFAULT = 8'h00;
	localparam logic [1:0] RZQ_RESET = 2'h0;

	// ---------------------------------------------------------------
	// apb register map
	// ---------------------------------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_FEAT1 = 8'h08;
	localparam logic [7:0] REG_FEAT2 = 8'h0C;
	localparam logic [7:0] REG_IOCFG = 8'h10;
	localparam logic [7:0] REG_RESETS = 8'h14;
	localparam logic [2:0] CTRL_RESET = 3'h0;

	// ---------------------------------------------------------------
	// sequencer states
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		S_POWER = 3'b000,
		S_NOPWAIT = 3'b001,
		S_AUTOINIT = 3'b011,
		S_IDLE = 3'b010,
		S_ZQCAL = 3'b110
	} lpi_state_t;

	typedef struct packed {
		lpi_state_t state;
		logic idle;
		logic [7:0] cnt;
		logic clkPrev;
		logic busy;
		logic [1:0] rzq;
		logic [7:0] feat1;
		logic [7:0] feat2;
		logic [7:0] iocfg;
		logic zqSupport;
		logic [1:0] zqResult;
		logic [7:0] resets;
		logic [7:0] rdData;
		logic rdValid;
		logic dqOeN;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} lpi_regs_t;

endpackage

/* core/lpi_sync.sv */
// two-flop synchroniser for a group of link pins
`timescale 1ns/1ns
module lpi_sync #(
	parameter int WIDTH = 1
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [WIDTH-1:0] async,
	output logic [WIDTH-1:0] synced
);
	logic [WIDTH-1:0] stage1;

	// ---------------------------------------------------------------
	// one pair of flops per bit
	// ---------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			always_ff @(posedge ref_clk or negedge rstn) begin
				if (!rstn) begin
					stage1[i] <= 1'b0;
					synced[i] <= 1'b0;
				end else begin
					stage1[i] <= async[i];
					synced[i] <= stage1[i];
				end
			end
		end
	endgenerate
endmodule

/* test/lpi_host.sv */
// memory controller model driving the link pins
`timescale 1ns/1ns
module lpi_host (
	input wire logic ref_clk,
	output logic memClk,
	output logic cke,
	output logic csN,
	output logic [2:0] cmdCode,
	output logic [7:0] cmdAddr,
	output logic [7:0] cmdData
);
	import lpi_pkg::*;
	initial begin
		memClk = 1'b0;
		cke = 1'b0;
		csN = 1'b1;
		cmdCode = 3'h0;
		cmdAddr = 8'h00;
		cmdData = 8'h00;
	end
	// one link clock period per command, pins driven to the inverted command between frames
	task automatic send(input logic [2:0] c, input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		csN <= 1'b0;
		cmdCode <= c;
		cmdAddr <= a;
		cmdData <= d;
		repeat (4) @(posedge ref_clk);
		memClk <= 1'b1;
		repeat (4) @(posedge ref_clk);
		memClk <= 1'b0;
		csN <= 1'b1;
		cmdCode <= ~c;
		cmdAddr <= ~a;
		cmdData <= ~d;
	endtask
	task automatic setCke(input logic v);
		@(posedge ref_clk);
		cke <= v;
	endtask
endmodule

/* test/lpi_init_seq_assertions.sv */
// port checker for the init sequencer
`timescale 1ns/1ns
module lpi_chk #(
	parameter int AUTO_CYC = lpi_pkg::AUTOINIT_CYC,
	parameter int ZQ_CYC = lpi_pkg::ZQINIT_CYC
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic cke,
	input wire logic [7:0] rdData,
	input wire logic rdValid,
	input wire logic dqOeN,
	input wire logic memIdle,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr
);
	import lpi_pkg::*;
	localparam int LIM = AUTO_CYC + ZQ_CYC;
	default clocking @(posedge ref_clk);
	endclocking
	default disable iff (!rstn);
	a_oe_read: assert property (!dqOeN |-> rdValid) else $error("oe outside read");
	a_oe_cke: assert property (!cke [*4] |-> dqOeN) else $error("oe with cke low");
	a_read_pulse: assert property (rdValid |=> !rdValid) else $error("long read");
	a_idle_busy: assert property (
		rdValid && memIdle && $past(memIdle) |-> !rdData[0]) else $error("busy in idle");
	a_init_bound: assert property ($fell(memIdle) |-> ##[1:LIM] memIdle)
		else $error("init too long");
	a_rd_hold: assert property (!rdValid |-> $stable(rdData)) else $error("data moved");
	a_apb_ready: assert property (psel && !penable |=> pready) else $error("no ready");
	a_apb_err: assert property (pready && paddr > REG_RESETS |-> pslverr) else $error("no err");
	cover property (rdValid && rdData[0]);
	cover property (pready && pslverr);
	cover property ($rose(memIdle));
endmodule
bind lpi_init_seq lpi_chk #(.AUTO_CYC(AUTO_CYC), .ZQ_CYC(ZQ_CYC)) i_lpi_chk (
	.ref_clk, .rstn, .cke, .rdData, .rdValid, .dqOeN, .memIdle,
	.psel, .penable, .paddr, .pready, .pslverr
);

/* test/tb.sv */
// self-checking bench for the init sequencer
`timescale 1ns/1ns
module tb;
	import lpi_pkg::*;
	typedef struct {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] x; logic e;} lpi_row_t;
	logic ref_clk = 1'b0;
	logic rstn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic memClk, cke, csN, dqOeN, rdValid, memIdle, pready, pslverr, e;
	logic [2:0] cmdCode;
	logic [7:0] cmdAddr, cmdData, rdData, r8;
	logic [31:0] prdata, r;
	int errors = 0;
	int checks = 0;
	int cyc = 0;
	lpi_row_t rows[9] = '{'{0, REG_STATUS, 0, 32'h20, 0}, '{0, REG_FEAT1, 0, 0, 0},
		'{0, REG_RESETS, 0, 0, 0}, '{1, REG_CTRL, 32'h5, 0, 0}, '{0, REG_CTRL, 0, 32'h5, 0},
		'{1, REG_STATUS, 32'hFF, 0, 0}, '{0, REG_STATUS, 0, 32'h20, 0},
		'{1, 8'h18, 32'h1, 0, 1}, '{0, 8'h18, 0, 0, 1}};
	always #50 ref_clk = ~ref_clk;
	lpi_init_seq i_lpi_init_seq (.ref_clk, .rstn, .memClk, .cke, .csN, .cmdCode, .cmdAddr,
		.cmdData, .rdData, .rdValid, .dqOeN, .memIdle, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr);
	lpi_host i_lpi_host (.ref_clk, .memClk, .cke, .csN, .cmdCode, .cmdAddr, .cmdData);
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x) begin
			errors++;
			$display("MISMATCH %0t seen %h expected %h", $time, s, x);
		end
	endtask
	task automatic results;
		$display("errors %0d checks %0d", errors, checks);
		if (errors == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 5000) begin
			errors++;
			results();
		end
	end
	task automatic rstChk;
		@(negedge ref_clk);
		chk(32'(rdValid), 32'h0);
		chk(32'(dqOeN), 32'h1);
		chk(32'(memIdle), 32'h0);
		chk(32'(pready), 32'h0);
		chk(32'(pslverr), 32'h0);
		chk(prdata, 32'h0);
		chk(32'(rdData), 32'h0);
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic mrr(input logic [7:0] a);
		int n;
		n = 0;
		fork
			i_lpi_host.send(CMD_MRR, a, 8'h00);
			begin
				while (rdValid !== 1'b1 && n < 12) begin
					@(negedge ref_clk);
					n++;
				end
				r8 = rdData;
				chk(32'(rdValid), 32'h1);
				chk(32'(dqOeN), 32'h0);
			end
		join
	endtask
	task automatic reinit;
		i_lpi_host.send(CMD_PREA, 8'h00, 8'h00);
		i_lpi_host.send(CMD_MRW, MA_RESET, 8'h00);
		repeat (2) i_lpi_host.send(CMD_NOP, 8'h00, 8'h00);
		mrr(MA_INFO);
		chk(32'(r8), 32'h01);
		repeat (15) if (r8[0] !== 1'b0) mrr(MA_INFO);
		chk(32'(r8), 32'h00);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(r, 32'h12);
	endtask
	initial begin
		repeat (3) @(posedge ref_clk);
		rstChk();
		@(posedge ref_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		foreach (rows[i]) begin
			apb(rows[i].w, rows[i].a, rows[i].d);
			chk(32'(e), 32'(rows[i].e));
			if (!rows[i].w) chk(r, rows[i].x);
		end
		repeat (5) i_lpi_host.send(CMD_NOP, 8'h00, 8'h00);
		i_lpi_host.setCke(1'b1);
		repeat (5) i_lpi_host.send(CMD_NOP, 8'h00, 8'h00);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(r, 32'h31);
		reinit();
		apb(1'b0, REG_RESETS, 32'h0);
		chk(r, 32'h01);
		mrr(8'h05);
		chk(32'(r8), 32'h00);
		for (int i = 1; i < 4; i++) begin
			i_lpi_host.send(CMD_MRW, 8'(i), 8'hA0 + 8'(i));
			apb(1'b0, 8'(4 + 4 * i), 32'h0);
			chk(r, 32'hA0 + 32'(i));
		end
		i_lpi_host.send(CMD_MRW, MA_ZQCAL, 8'hFF);
		@(negedge ref_clk);
		chk(32'(memIdle), 32'h0);
		repeat (12) @(posedge ref_clk);
		mrr(MA_INFO);
		chk(32'(r8), 32'h10);
		apb(1'b1, REG_CTRL, 32'h0);
		i_lpi_host.send(CMD_MRW, MA_ZQCAL, 8'hFF);
		@(negedge ref_clk);
		chk(32'(memIdle), 32'h1);
		reinit();
		apb(1'b0, REG_FEAT1, 32'h0);
		chk(r, 32'h0);
		i_lpi_host.setCke(1'b0);
		repeat (4) @(posedge ref_clk);
		fork
			i_lpi_host.send(CMD_MRR, MA_INFO, 8'h00);
			repeat (12) @(negedge ref_clk) chk(32'(rdValid), 32'h0);
		join
		// mid-run reset returns every output and register to its reset value
		@(posedge ref_clk);
		rstn <= 1'b0;
		repeat (2) @(posedge ref_clk);
		rstChk();
		@(posedge ref_clk);
		rstn <= 1'b1;
		repeat (3) @(posedge ref_clk);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(r, 32'h20);
		apb(1'b0, REG_RESETS, 32'h0);
		chk(r, 32'h0);
		apb(1'b0, REG_CTRL, 32'h0);
		chk(r, 32'h0);
		results();
	end
endmodule
